// ==== design/nvc_ctrl.sv ====
/*
 nonvolatile byte access controller: io registers, timed write unlock,
 self-timed programming, cpu stall and ready interrupt request.
 assumes the core issues single-cycle io strobes and honours cpu_stall.
 programming time is counted on osc_tick, pulses from the calibrated oscillator.
*/
// Function
// - byte array of 256 or 512 bytes, each byte read and written alone.
// - a read stalls the core four cycles.
// - starting a write stalls the core two cycles.
// - write is self-timed; completion shows as write strobe reading zero.
// - a write in progress survives system reset and completes.
// - address is nine bits; upper bits read zero.
// - address undefined after reset; software loads it before access.
// - data register holds byte to write, or byte read back.
// - mode field picks atomic, erase only or write only; 11 reserved.
// - mode writes ignored while write strobe is set.
// - reset clears mode unless programming is in progress.
// - ready request needs enable bit and global interrupt enable.
// - ready request is a level while write strobe is zero.
// - no ready request during write or program store operation.
// - bit set and clear on control touch only the addressed bit.
// - arm bit self-clears after four cycles; strobe must follow inside that window.
// - write strobe clears when programming time has elapsed.
// - read strobe fetches addressed byte into data register at once.
// - during a write, array reads and address changes are blocked.
`timescale 1ns/1ps
module nvc_ctrl #(
   parameter int DEPTH       = 512,
   parameter int ATOMIC_CYC  = nvc_pkg::NVC_ATOMIC_CYC,
   parameter int SPLIT_CYC   = nvc_pkg::NVC_SPLIT_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // io bus from core
   input  wire logic [5:0]  io_addr,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        io_bit_set,
   input  wire logic        io_bit_clr,
   input  wire logic [2:0]  io_bit_sel,
   output logic      [7:0]  io_rdata,
   // core status
   input  wire logic        cpu_flags_ie,
   input  wire logic        program_store_busy,
   input  wire logic        osc_tick,
   output logic             cpu_stall,
   output logic             ready_irq
);
   import nvc_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [7:0]            mem [DEPTH];
   logic [8:0]            idx_ff, nxt_idx;
   logic [7:0]            data_ff, nxt_data;
   logic [1:0]            pm_ff, nxt_pm;
   logic                  rie_ff, nxt_rie;
   logic                  arm_ff, nxt_arm;
   logic [2:0]            arm_cnt_ff, nxt_arm_cnt;
   // busy starts clear at power-up; reset only keeps it from setting, never clears it, so a running write completes
   logic                  busy_ff = 1'b0;
   logic                  nxt_busy;
   logic [NVC_TMR_W-1:0]  tmr_ff, nxt_tmr;
   logic [2:0]            stall_cnt_ff, nxt_stall_cnt;
   logic                  stall_ff, nxt_stall;
   logic                  irq_ff, nxt_irq;
   logic [7:0]            rdata_ff, nxt_rdata;
   logic                  mem_we;
   logic [1:0]            op_ff, nxt_op;
   logic                  rst_sys_ff;
   logic [8:0]            wr_idx_ff, nxt_wr_idx;
   logic [7:0]            wr_dat_ff, nxt_wr_dat;

   function automatic logic [7:0] ctrl_view(input logic [1:0] pm, input logic rie, input logic arm,
                                            input logic busy);
      ctrl_view = {2'b00, pm, rie, arm, busy, 1'b0};
   endfunction

   function automatic logic [NVC_TMR_W-1:0] prog_len(input logic [1:0] pm);
      prog_len = (pm == NVC_PM_ATOMIC) ? NVC_TMR_W'(ATOMIC_CYC) : NVC_TMR_W'(SPLIT_CYC);
   endfunction

   logic       ctrl_hit, ctrl_wr_any;
   logic [7:0] ctrl_old, ctrl_new;
   logic       set_rd, set_wr;

   always_comb begin
      ctrl_hit = (io_addr == NVC_CTRL_OFS) && (NVC_CTRL_OFS <= NVC_BITIO_MAX);
      ctrl_old = ctrl_view(pm_ff, rie_ff, arm_ff, busy_ff);
      ctrl_new = ctrl_old;
      ctrl_wr_any = 1'b0;
      if (ctrl_hit && io_wr) begin
         ctrl_new = io_wdata;
         ctrl_wr_any = 1'b1;
      end else if (ctrl_hit && io_bit_set) begin
         ctrl_new[io_bit_sel] = 1'b1;
         ctrl_wr_any = 1'b1;
      end else if (ctrl_hit && io_bit_clr) begin
         ctrl_new[io_bit_sel] = 1'b0;
         ctrl_wr_any = 1'b1;
      end
      set_rd = ctrl_wr_any && ctrl_new[NVC_RD_BIT] && !busy_ff;
      set_wr = ctrl_wr_any && ctrl_new[NVC_WR_BIT] && !ctrl_old[NVC_WR_BIT] && arm_ff
               && !busy_ff && !program_store_busy;
   end

   always_comb begin
      nxt_idx       = idx_ff;
      nxt_data      = data_ff;
      nxt_pm        = pm_ff;
      nxt_rie       = rie_ff;
      nxt_arm       = arm_ff;
      nxt_arm_cnt   = arm_cnt_ff;
      nxt_busy      = busy_ff;
      nxt_tmr       = tmr_ff;
      nxt_op        = op_ff;
      nxt_wr_idx    = wr_idx_ff;
      nxt_wr_dat    = wr_dat_ff;
      nxt_stall     = stall_ff;
      nxt_stall_cnt = stall_cnt_ff;
      mem_we        = 1'b0;
      if (io_wr && !busy_ff && io_addr == NVC_ADDRL_OFS)
         nxt_idx[7:0] = io_wdata;
      if (io_wr && !busy_ff && io_addr == NVC_ADDRH_OFS)
         nxt_idx[8] = io_wdata[0];
      if (io_wr && io_addr == NVC_DATA_OFS)
         nxt_data = io_wdata;
      if (ctrl_wr_any) begin
         nxt_rie = ctrl_new[NVC_RIE_BIT];
         if (!busy_ff)
            nxt_pm = ctrl_new[NVC_PM_HI:NVC_PM_LO];
         if (ctrl_new[NVC_ARM_BIT] && !arm_ff) begin
            nxt_arm     = 1'b1;
            nxt_arm_cnt = 3'(NVC_ARM_CYC - 1);
         end
      end
      if (arm_ff) begin
         if (arm_cnt_ff == 3'h0)
            nxt_arm = 1'b0;
         else
            nxt_arm_cnt = arm_cnt_ff - 3'h1;
      end
      if (set_rd) begin
         nxt_data      = mem[idx_ff[AW-1:0]];
         nxt_stall     = 1'b1;
         nxt_stall_cnt = 3'(NVC_RD_STALL_CYC - 1);
      end
      if (set_wr) begin
         nxt_busy      = 1'b1;
         nxt_arm       = 1'b0;
         nxt_op        = pm_ff;
         nxt_wr_idx    = idx_ff;
         nxt_wr_dat    = data_ff;
         nxt_tmr       = prog_len(pm_ff);
         nxt_stall     = 1'b1;
         nxt_stall_cnt = 3'(NVC_WR_STALL_CYC - 1);
      end
      if (stall_ff && !set_rd && !set_wr) begin
         if (stall_cnt_ff == 3'h0)
            nxt_stall = 1'b0;
         else
            nxt_stall_cnt = stall_cnt_ff - 3'h1;
      end
      if (busy_ff && osc_tick) begin
         if (tmr_ff == NVC_TMR_W'(0)) begin
            nxt_busy = 1'b0;
            mem_we   = (op_ff != NVC_PM_RSVD);
         end else
            nxt_tmr = tmr_ff - NVC_TMR_W'(1);
      end
      nxt_irq = rie_ff && cpu_flags_ie && !busy_ff && !program_store_busy;
      unique case (io_addr)
         NVC_CTRL_OFS:  nxt_rdata = ctrl_old;
         NVC_DATA_OFS:  nxt_rdata = data_ff;
         NVC_ADDRL_OFS: nxt_rdata = idx_ff[7:0];
         NVC_ADDRH_OFS: nxt_rdata = {7'h00, idx_ff[8]};
         default:       nxt_rdata = 8'h00;
      endcase
      if (!io_rd)
         nxt_rdata = rdata_ff;
   end

   // array write; reserved mode programs nothing
   always_ff @(posedge clk) begin
      if (mem_we) begin
         unique case (op_ff)
            NVC_PM_ATOMIC: mem[wr_idx_ff[AW-1:0]] <= wr_dat_ff;
            NVC_PM_ERASE:  mem[wr_idx_ff[AW-1:0]] <= 8'hFF;
            NVC_PM_WRITE:  mem[wr_idx_ff[AW-1:0]] <= mem[wr_idx_ff[AW-1:0]] & wr_dat_ff;
            default:       mem[wr_idx_ff[AW-1:0]] <= mem[wr_idx_ff[AW-1:0]];
         endcase
      end
   end

   // index and data undefined at reset, software loads them first
   always_ff @(posedge clk) begin
      idx_ff     <= nxt_idx;
      data_ff    <= nxt_data;
      wr_idx_ff  <= nxt_wr_idx;
      wr_dat_ff  <= nxt_wr_dat;
      op_ff      <= nxt_op;
   end

   // programming state is not reset so a running write completes
   always_ff @(posedge clk) begin
      busy_ff <= rst_sys_ff ? (busy_ff && nxt_busy) : nxt_busy;
      tmr_ff  <= nxt_tmr;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rst_sys_ff <= 1'b1;
      else
         rst_sys_ff <= 1'b0;
   end

   // mode is held across reset while busy
   always_ff @(posedge clk) begin
      if (rst && !busy_ff)
         pm_ff <= NVC_PM_RST;
      else if (!rst)
         pm_ff <= nxt_pm;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rie_ff       <= 1'b0;
         arm_ff       <= 1'b0;
         arm_cnt_ff   <= 3'h0;
         stall_ff     <= 1'b0;
         stall_cnt_ff <= 3'h0;
         irq_ff       <= 1'b0;
         rdata_ff     <= 8'h00;
      end else begin
         rie_ff       <= nxt_rie;
         arm_ff       <= nxt_arm;
         arm_cnt_ff   <= nxt_arm_cnt;
         stall_ff     <= nxt_stall;
         stall_cnt_ff <= nxt_stall_cnt;
         irq_ff       <= nxt_irq;
         rdata_ff     <= nxt_rdata;
      end
   end

   assign io_rdata  = rdata_ff;
   assign cpu_stall = stall_ff;
   assign ready_irq = irq_ff;
endmodule // nvc_ctrl

// ==== pkg/nvc_pkg.sv ====
/*
 package for the nonvolatile byte access controller: io offsets, control
 bit positions, mode codes, stall counts and programming times.
 assumes a 100 MHz cpu clock and byte-wide io accesses.
*/
package nvc_pkg;
   // io offsets
   localparam logic [5:0] NVC_CTRL_OFS   = 6'h1F;
   localparam logic [5:0] NVC_DATA_OFS   = 6'h20;
   localparam logic [5:0] NVC_ADDRL_OFS  = 6'h21;
   localparam logic [5:0] NVC_ADDRH_OFS  = 6'h22;
   localparam logic [5:0] NVC_BITIO_MAX  = 6'h1F;
   // control bit positions
   localparam int NVC_RD_BIT   = 0;
   localparam int NVC_WR_BIT   = 1;
   localparam int NVC_ARM_BIT  = 2;
   localparam int NVC_RIE_BIT  = 3;
   localparam int NVC_PM_LO    = 4;
   localparam int NVC_PM_HI    = 5;
   // mode codes
   typedef enum logic [1:0] {
      NVC_PM_ATOMIC = 2'b00,
      NVC_PM_ERASE  = 2'b01,
      NVC_PM_WRITE  = 2'b10,
      NVC_PM_RSVD   = 2'b11
   } nvc_pm_e;
   localparam logic [1:0] NVC_PM_RST = 2'b00;
   // timing
   localparam int CLK_HZ            = 100_000_000;
   localparam int NVC_ARM_CYC       = 4;
   localparam int NVC_RD_STALL_CYC  = 4;
   localparam int NVC_WR_STALL_CYC  = 2;
   localparam int NVC_T_ATOMIC_US   = 3400;
   localparam int NVC_T_SPLIT_US    = 1800;
   localparam int NVC_ATOMIC_CYC    = NVC_T_ATOMIC_US * (CLK_HZ / 1_000_000);
   localparam int NVC_SPLIT_CYC     = NVC_T_SPLIT_US * (CLK_HZ / 1_000_000);
   localparam int NVC_TMR_W         = 20;
endpackage

// ==== bench/nvc_ctrl_properties.sv ====
/* checker for nvc_ctrl, ports only.
 assumes binding onto nvc_ctrl and a single clock domain. */
`timescale 1ns/1ps
module nvc_ctrl_properties import nvc_pkg::*; #(
   parameter int DEPTH = 512, parameter int ATOMIC_CYC = 20, parameter int SPLIT_CYC = 10
) (
   input wire logic       clk, rst, io_wr, io_rd, io_bit_set, io_bit_clr, osc_tick,
   input wire logic       cpu_flags_ie, program_store_busy, cpu_stall, ready_irq,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata, io_rdata,
   input wire logic [2:0] io_bit_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [3:0] run_ff, nxt_run;
   wire ctl = io_addr == NVC_CTRL_OFS;
   always_comb nxt_run = cpu_stall ? run_ff + 4'h1 : 4'h0;
   always_ff @(posedge clk or posedge rst) if (rst) run_ff <= 4'h0; else run_ff <= nxt_run;
   sequence wr_start;
      ctl && io_bit_set && io_bit_sel == 3'h2 && !program_store_busy ##1 ctl && io_bit_set && io_bit_sel == 3'h1;
   endsequence
   a_stall_len: assert property ($fell(cpu_stall) |-> run_ff == 4'h2 || run_ff == 4'h4)
      else $error("stall length");
   a_read_stall: assert property (ctl && io_bit_set && io_bit_sel == 3'h0 && !cpu_stall |=> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read stall");
   a_write_stall: assert property (wr_start |=> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write stall");
   a_arm_expiry: assert property (ctl && io_bit_set && io_bit_sel == 3'h2 ##1 !io_bit_set [*4]
      ##1 ctl && io_bit_set && io_bit_sel == 3'h1 |=> !cpu_stall) else $error("late strobe took");
   a_irq_cause: assert property (ready_irq |-> $past(cpu_flags_ie) && !$past(program_store_busy))
      else $error("irq cause");
   a_irq_write_block: assert property (wr_start |=> ##1 !ready_irq [*3]) else $error("irq in write");
   a_rdata_hold: assert property (!$past(io_rd) |-> $stable(io_rdata)) else $error("rdata moved");
   a_addr_rsvd: assert property ($past(io_rd && io_addr == NVC_ADDRH_OFS) |-> io_rdata[7:1] == 7'h00)
      else $error("addr reserved");
   c_write: cover property (wr_start ##3 !cpu_stall);
   c_read: cover property (ctl && io_bit_set && io_bit_sel == 3'h0);
   c_irq: cover property ($rose(ready_irq));
endmodule // nvc_ctrl_properties
bind nvc_ctrl nvc_ctrl_properties #(.DEPTH(DEPTH), .ATOMIC_CYC(ATOMIC_CYC), .SPLIT_CYC(SPLIT_CYC)) props_u (
   .clk(clk), .rst(rst), .io_wr(io_wr), .io_rd(io_rd), .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr),
   .osc_tick(osc_tick), .cpu_flags_ie(cpu_flags_ie), .program_store_busy(program_store_busy),
   .cpu_stall(cpu_stall), .ready_irq(ready_irq), .io_addr(io_addr), .io_wdata(io_wdata),
   .io_rdata(io_rdata), .io_bit_sel(io_bit_sel));

// ==== bench/nvc_core_model.sv ====
/* core model issuing io accesses.
 assumes the bench calls go and rd; requests wait out cpu_stall. */
`timescale 1ns/1ps
module nvc_core_model import nvc_pkg::*; (
   input wire logic       clk, cpu_stall,
   input wire logic [7:0] io_rdata,
   output logic     [5:0] io_addr,
   output logic     [7:0] io_wdata,
   output logic     [2:0] io_bit_sel,
   output logic           io_wr, io_rd, io_bit_set, io_bit_clr
);
   initial {io_addr, io_wdata, io_bit_sel, io_wr, io_rd, io_bit_set, io_bit_clr} = '0;
   task automatic go(input logic [5:0] a, input logic [7:0] d, input logic [2:0] s, input logic [3:0] k);
      @(negedge clk);
      while (cpu_stall) @(negedge clk);
      {io_addr, io_wdata, io_bit_sel} = {a, d, s};
      {io_wr, io_rd, io_bit_set, io_bit_clr} = k;
      @(posedge clk);
      {io_wr, io_rd, io_bit_set, io_bit_clr} <= 4'h0;
      {io_addr, io_wdata, io_bit_sel} <= ~{a, d, s}; // idle lines must not hold last value
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      go(a, 8'h00, 3'h0, 4'h4);
      @(negedge clk);
      d = io_rdata;
   endtask
endmodule // nvc_core_model

// ==== bench/tb_nvc_ctrl.sv ====
/* bench for nvc_ctrl: core model drives io, array model predicts bytes.
 assumes short programming counts 20/10. */
`timescale 1ns/1ps
module tb_nvc_ctrl;
   import nvc_pkg::*;
   logic       clk = 0, rst = 1, ie = 0, psb = 0, tick = 1;
   logic       io_wr, io_rd, io_bit_set, io_bit_clr, cpu_stall, ready_irq;
   logic [5:0] io_addr;
   logic [7:0] io_wdata, io_rdata, v;
   logic [2:0] io_bit_sel;
   int         bad_count = 0, compares = 0, n, a, mem [512];
   nvc_ctrl #(.DEPTH(512), .ATOMIC_CYC(20), .SPLIT_CYC(10)) dut_u (.clk(clk), .rst(rst), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr),
      .io_bit_sel(io_bit_sel), .io_rdata(io_rdata), .cpu_flags_ie(ie), .program_store_busy(psb),
      .osc_tick(tick), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
   nvc_core_model core_u (.clk(clk), .cpu_stall(cpu_stall), .io_rdata(io_rdata), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_bit_sel(io_bit_sel), .io_wr(io_wr), .io_rd(io_rd), .io_bit_set(io_bit_set),
      .io_bit_clr(io_bit_clr));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bset(input logic [2:0] s, input logic [3:0] k = 4'h2);
      core_u.go(NVC_CTRL_OFS, 8'h00, s, k);
   endtask
   task automatic put(input logic [5:0] o, input logic [7:0] d);
      core_u.go(o, d, 3'h0, 4'h8);
   endtask
   task automatic wait_idle;
      n = 0;
      do begin core_u.rd(NVC_CTRL_OFS, v); n++; end while (v[1] === 1'b1 && n < 200);
      chk({7'h0, v[1]}, 8'h00);
   endtask
   task automatic nvw(input logic [7:0] d, input logic [1:0] m);
      put(NVC_ADDRH_OFS, {7'h0, a[8]});
      put(NVC_ADDRL_OFS, a[7:0]);
      put(NVC_DATA_OFS, d);
      put(NVC_CTRL_OFS, {2'h0, m, 4'h0});
      bset(NVC_ARM_BIT);
      bset(NVC_WR_BIT);
      core_u.rd(NVC_CTRL_OFS, v);
      chk({5'h0, v[5:4], v[1]}, {5'h0, m, 1'b1});
      mem[a] = m == 2'b00 ? d : m == 2'b01 ? 8'hFF : m == 2'b10 ? mem[a] & d : mem[a];
   endtask
   task automatic nvr;
      put(NVC_ADDRH_OFS, {7'h0, a[8]});
      put(NVC_ADDRL_OFS, a[7:0]);
      bset(NVC_RD_BIT);
      core_u.rd(NVC_DATA_OFS, v);
      chk(v, mem[a][7:0]);
   endtask
   initial forever #5 clk = ~clk;
   always @(negedge clk) tick <= ($urandom % 4) != 0;
   initial begin
      #400000; // some 14 writes of under 100 cycles each, with wide margin
      bad_count++;
      print_verdict;
   end
   initial begin
      void'($urandom(16));
      repeat (8) @(negedge clk);
      rst = 0;
      for (int k = 0; k < 3; k++) begin
         a = $urandom % 512;
         for (int m = 0; m < 4; m++) begin nvw(8'($urandom), 2'(m)); wait_idle; nvr; end
         core_u.rd(NVC_ADDRH_OFS, v);
         chk(v, {7'h0, a[8]});
      end
      $display("test modes done");
      nvw(8'h5A, 2'b00);
      put(NVC_CTRL_OFS, 8'h20);
      put(NVC_ADDRL_OFS, ~a[7:0]);
      core_u.rd(NVC_CTRL_OFS, v);
      chk({6'h0, v[5:4]}, 8'h00);
      core_u.rd(NVC_ADDRL_OFS, v);
      chk(v, a[7:0]);
      wait_idle; nvr;
      bset(NVC_ARM_BIT);
      repeat (4) put(NVC_DATA_OFS, 8'h00);
      bset(NVC_WR_BIT);
      core_u.rd(NVC_CTRL_OFS, v);
      chk({7'h0, v[1]}, 8'h00);
      nvr;
      $display("test blocking done");
      nvw(8'h0F, 2'b10);
      rst = 1; @(negedge clk); rst = 0;
      core_u.rd(NVC_CTRL_OFS, v);
      chk({6'h0, v[5:4]}, 8'h02);
      wait_idle; nvr;
      rst = 1; @(negedge clk); rst = 0;
      core_u.rd(NVC_CTRL_OFS, v);
      chk({6'h0, v[5:4]}, 8'h00);
      $display("test reset done");
      ie = 1;
      put(NVC_CTRL_OFS, 8'h10);
      bset(NVC_RIE_BIT);
      core_u.rd(NVC_CTRL_OFS, v);
      chk(v, 8'h18);
      chk({7'h0, ready_irq}, 8'h01);
      psb = 1; repeat (2) @(negedge clk);
      chk({7'h0, ready_irq}, 8'h00);
      psb = 0; ie = 0; repeat (2) @(negedge clk);
      chk({7'h0, ready_irq}, 8'h00);
      ie = 1;
      bset(NVC_RIE_BIT, 4'h1);
      core_u.rd(NVC_CTRL_OFS, v);
      chk(v, 8'h10);
      chk({7'h0, ready_irq}, 8'h00);
      $display("test irq done");
      print_verdict;
   end
endmodule // tb_nvc_ctrl
